// File: design/sec_device.sv
// Security-mode logic and parameter store of the gauge.
// Assumes the host keeps one command outstanding and waits for rsp_valid.
//
// How it works
// RQ1 - Three levels gate store and maker block
// RQ2 - Host avoids private locations in block writes
// RQ3 - Key subclass writable only at full access
// RQ4 - Each transition needs its own key pair
// RQ5 - Key words back to back, else void; here only another control write in between voids them
// RQ6 - Host keys differ from subcommand codes
// RQ7 - Sealed flag set while sealed, cleared unsealing
// RQ8 - Full access flag cleared on full key
// RQ9 - Both key sets kept in store, two-byte words
// RQ10 - Host sends key words byte swapped
// RQ11 - Security subclass holds three four-byte keys
// RQ12 - Operation config byte default at subclass 64
// RQ13 - Charge level step default one, offset three
// RQ14 - Design capacity default at subclass 48
// RQ15 - Terminate voltage default at subclass 80
// RQ16 - Maker block A 32 zero bytes
// RQ17 - Resistance table flags at offset zero
// RQ18 - Level commands arrive on control word port
// RQ19 - Sealed refuses class and general block select
// RQ20 - Commit only on correct complemented checksum
// RQ21 - Wrong keys change nothing, await fresh pair
`timescale 1ns/1ps
`default_nettype none
module sec_device
    import sec_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Command link
    sec_if.dev link,
    // User-side status
    output logic [2:0] level,
    output logic [15:0] ctl_status,
    output logic commit_pulse
);
    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    // Slot 7 is an unknown subclass; it is never committed
    logic [7:0] mem_q [0:511];
    logic [7:0] buf_q [0:SEC_BLOCK_BYTES-1];
    sec_level_t lvl_q;
    logic [7:0] class_q;
    logic [7:0] blk_q;
    logic bctl_q;
    logic ss_q;
    logic fas_q;
    logic rsp_valid_q;
    logic rsp_err_q;
    logic [15:0] rsp_rdata_q;
    logic commit_q;

    // Map subclass id to a storage slot
    function automatic logic [2:0] slot_of(input logic [7:0] id);
        logic [2:0] s;
        s = 3'h7;
        case (id)
            SEC_SC_DATA: s = 3'h0;
            SEC_SC_MFR: s = 3'h1;
            SEC_SC_REGS: s = 3'h2;
            SEC_SC_GAUGE: s = 3'h3;
            SEC_SC_RA0: s = 3'h4;
            SEC_SC_RA0X: s = 3'h5;
            SEC_SC_SECURITY: s = 3'h6;
            default: s = 3'h7;
        endcase
        return s;
    endfunction : slot_of

    // Factory content of one byte, multi-byte values high byte first
    function automatic logic [7:0] dflt(input logic [2:0] s, input int o);
        logic [7:0] v;
        v = 8'h00;
        case (s)
            3'h0: if (o == SEC_OFS_DCAP) v = SEC_DEF_DCAP[15:8]; // RQ14
                  else if (o == SEC_OFS_DCAP + 1) v = SEC_DEF_DCAP[7:0];
            3'h2: if (o == SEC_OFS_OPCFG) v = SEC_DEF_OPCFG; // RQ12
                  else if (o == SEC_OFS_STEP) v = SEC_DEF_STEP; // RQ13
            3'h3: if (o == SEC_OFS_TERMV) v = SEC_DEF_TERMV[15:8]; // RQ15
                  else if (o == SEC_OFS_TERMV + 1) v = SEC_DEF_TERMV[7:0];
            3'h4: if (o == SEC_OFS_RAFLAG) v = SEC_DEF_RA0_FLAG[15:8]; // RQ17
                  else if (o == SEC_OFS_RAFLAG + 1) v = SEC_DEF_RA0_FLAG[7:0];
            3'h5: if (o == SEC_OFS_RAFLAG) v = SEC_DEF_RA0X_FLAG[15:8]; // RQ17
                  else if (o == SEC_OFS_RAFLAG + 1) v = SEC_DEF_RA0X_FLAG[7:0];
            3'h6: if (o >= SEC_OFS_UNSEAL_KEY && o < SEC_OFS_UNSEAL_KEY + 4) // RQ11
                      v = SEC_DEF_UNSEAL_KEY[8*(3-(o-SEC_OFS_UNSEAL_KEY)) +: 8];
                  else if (o >= SEC_OFS_FULL_KEY && o < SEC_OFS_FULL_KEY + 4)
                      v = SEC_DEF_FULL_KEY[8*(3-(o-SEC_OFS_FULL_KEY)) +: 8];
                  else if (o >= SEC_OFS_RESTORE_KEY && o < SEC_OFS_RESTORE_KEY + 4)
                      v = SEC_DEF_RESTORE_KEY[8*(3-(o-SEC_OFS_RESTORE_KEY)) +: 8];
            default: v = 8'h00; // RQ16
        endcase
        return v;
    endfunction : dflt

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    wire logic wr = link.cmd_valid && link.cmd_write;
    wire logic rd = link.cmd_valid && !link.cmd_write;
    wire logic is_ctl = link.cmd_code == SEC_CMD_CTL;
    wire logic is_class = link.cmd_code == SEC_CMD_CLASS;
    wire logic is_blk = link.cmd_code == SEC_CMD_BLOCK;
    wire logic is_data = (link.cmd_code >= SEC_CMD_DATA_LO) && (link.cmd_code <= SEC_CMD_DATA_HI);
    wire logic is_ck = link.cmd_code == SEC_CMD_CKSUM;
    wire logic is_bctl = link.cmd_code == SEC_CMD_BCTL;
    wire logic sealed = lvl_q == SEC_SEALED;
    wire logic [4:0] data_ofs = link.cmd_code[4:0];
    wire logic ctl_wr = wr && is_ctl; // RQ18

    // Sealed: class and block control refused; only block select 0x01 to maker block A, control writes and other reads pass
    wire logic sel_mfr = sealed && wr && is_blk && (link.cmd_wdata[7:0] == 8'h01);
    wire logic refuse_sealed = sealed && link.cmd_valid
        && (is_class || is_bctl || (is_blk && wr && !sel_mfr) || (is_data && wr)
            || (is_ck && wr)); // RQ1 RQ19
    wire logic [2:0] slot = slot_of(class_q);
    wire logic [8:0] base = {slot, blk_q[0], 5'h00};

    // ------------------------------------------------------------
    // Block checksum and commit permission
    // ------------------------------------------------------------
    logic [7:0] sum;
    always_comb
    begin
        sum = 8'h00;
        for (int i = 0; i < SEC_BLOCK_BYTES; i++)
        begin
            sum = sum + buf_q[i];
        end
    end
    wire logic [7:0] cksum = ~sum;
    wire logic key_area = slot == 3'h6;
    wire logic key_lock = key_area && (lvl_q != SEC_FULL); // RQ3
    wire logic blk_ok = (slot != 3'h7) && (blk_q[7:1] == 7'h00);
    wire logic ck_wr = wr && is_ck && !sealed;
    wire logic commit = ck_wr && blk_ok && !key_lock
        && (link.cmd_wdata[7:0] == cksum); // RQ20

    // ------------------------------------------------------------
    // Key comparison, host words arrive byte swapped
    // ------------------------------------------------------------
    localparam logic [8:0] KEY_BASE = 9'h180;
    wire logic [15:0] uk0 = {mem_q[KEY_BASE + 9'd1], mem_q[KEY_BASE + 9'd0]}; // RQ9 RQ10
    wire logic [15:0] uk1 = {mem_q[KEY_BASE + 9'd3], mem_q[KEY_BASE + 9'd2]};
    wire logic [15:0] fk0 = {mem_q[KEY_BASE + 9'd5], mem_q[KEY_BASE + 9'd4]};
    wire logic [15:0] fk1 = {mem_q[KEY_BASE + 9'd7], mem_q[KEY_BASE + 9'd6]};
    wire logic unseal_hit;
    wire logic full_hit;

    sec_key_pair u_unseal (
        .clk(clk),
        .rst(rst),
        .ctl_wr(ctl_wr),
        .ctl_data(link.cmd_wdata),
        .key0(uk0),
        .key1(uk1),
        .match(unseal_hit)
    );
    sec_key_pair u_full (
        .clk(clk),
        .rst(rst),
        .ctl_wr(ctl_wr),
        .ctl_data(link.cmd_wdata),
        .key0(fk0),
        .key1(fk1),
        .match(full_hit)
    );

    // ------------------------------------------------------------
    // Level transitions
    // ------------------------------------------------------------
    // Mismatching pairs give no hit, so the level simply holds
    sec_level_t lvl_d;
    always_comb
    begin
        lvl_d = lvl_q; // RQ21
        unique case (lvl_q)
            SEC_SEALED: if (unseal_hit) lvl_d = SEC_UNSEALED; // RQ4
            SEC_UNSEALED:
                if (full_hit) lvl_d = SEC_FULL; // RQ4
                else if (ctl_wr && link.cmd_wdata == SEC_SUB_SEAL) lvl_d = SEC_SEALED;
            SEC_FULL: if (ctl_wr && link.cmd_wdata == SEC_SUB_SEAL) lvl_d = SEC_SEALED;
            default: lvl_d = SEC_SEALED;
        endcase
    end

    // Level and its state flags
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            lvl_q <= SEC_SEALED;
            ss_q <= 1'b1;
            fas_q <= 1'b1;
        end
        else
        begin
            lvl_q <= lvl_d;
            ss_q <= lvl_d == SEC_SEALED; // RQ7
            fas_q <= lvl_d != SEC_FULL; // RQ8
        end
    end

    // ------------------------------------------------------------
    // Selection and block buffer
    // ------------------------------------------------------------
    wire logic [7:0] class_d = sel_mfr ? SEC_SC_MFR : (wr && is_class && !sealed)
        ? link.cmd_wdata[7:0] : class_q;
    wire logic [7:0] blk_d = sel_mfr ? 8'h00 : (wr && is_blk && !sealed)
        ? link.cmd_wdata[7:0] : blk_q;
    wire logic reload = (class_d != class_q) || (blk_d != blk_q) || sel_mfr;
    wire logic [8:0] base_d = {slot_of(class_d), blk_d[0], 5'h00};

    // Buffer reloads from the store whenever the selection changes
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            class_q <= 8'h00;
            blk_q <= 8'h00;
            bctl_q <= 1'b0;
            for (int i = 0; i < SEC_BLOCK_BYTES; i++) buf_q[i] <= 8'h00;
        end
        else
        begin
            class_q <= class_d;
            blk_q <= blk_d;
            if (wr && is_bctl && !sealed) bctl_q <= link.cmd_wdata[0];
            if (reload)
            begin
                for (int i = 0; i < SEC_BLOCK_BYTES; i++) buf_q[i] <= mem_q[base_d + 9'(i)];
            end
            else if (wr && is_data && !sealed)
            begin
                buf_q[data_ofs] <= link.cmd_wdata[7:0];
            end
        end
    end

    // Store: factory image on reset, whole block on commit
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            for (int a = 0; a < 512; a++) mem_q[a] <= dflt(3'(a >> 6), a & 63);
        end
        else if (commit)
        begin
            for (int i = 0; i < SEC_BLOCK_BYTES; i++) mem_q[base + 9'(i)] <= buf_q[i];
        end
    end

    // ------------------------------------------------------------
    // Responses, one cycle after each command
    // ------------------------------------------------------------
    wire logic [15:0] status_w = 16'((32'(ss_q) << SEC_SS_BIT) | (32'(fas_q) << SEC_FAS_BIT));
    wire logic known = is_ctl || is_class || is_blk || is_data || is_ck || is_bctl;
    wire logic [15:0] rdata_w = is_ctl ? status_w : is_class ? {8'h00, class_q}
        : is_blk ? {8'h00, blk_q} : is_data ? {8'h00, buf_q[data_ofs]}
        : is_ck ? {8'h00, cksum} : {15'h0000, bctl_q};
    wire logic err_w = !known || refuse_sealed || (ck_wr && !commit);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rsp_valid_q <= 1'b0;
            rsp_err_q <= 1'b0;
            rsp_rdata_q <= 16'h0000;
            commit_q <= 1'b0;
        end
        else
        begin
            rsp_valid_q <= link.cmd_valid;
            rsp_err_q <= link.cmd_valid && err_w;
            rsp_rdata_q <= (rd && !err_w) ? rdata_w : 16'h0000;
            commit_q <= commit;
        end
    end

    assign link.rsp_valid = rsp_valid_q;
    assign link.rsp_err = rsp_err_q;
    assign link.rsp_rdata = rsp_rdata_q;
    assign level = lvl_q;
    assign ctl_status = status_w;
    assign commit_pulse = commit_q;
endmodule : sec_device
`default_nettype wire

// File: design/sec_pkg.sv
// Constants shared by both ends of the security-mode command link.
// Assumes one common clock; commands are word-wide and one at a time.
package sec_pkg;

    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [7:0] SEC_CMD_CTL = 8'h00;
    localparam logic [7:0] SEC_CMD_CLASS = 8'h3E;
    localparam logic [7:0] SEC_CMD_BLOCK = 8'h3F;
    localparam logic [7:0] SEC_CMD_DATA_LO = 8'h40;
    localparam logic [7:0] SEC_CMD_DATA_HI = 8'h5F;
    localparam logic [7:0] SEC_CMD_CKSUM = 8'h60;
    localparam logic [7:0] SEC_CMD_BCTL = 8'h61;
    localparam logic [15:0] SEC_SUB_SEAL = 16'h0020;

    // ------------------------------------------------------------
    // Control status word fields
    // ------------------------------------------------------------
    localparam int SEC_SS_BIT = 13;
    localparam int SEC_FAS_BIT = 14;

    // ------------------------------------------------------------
    // Parameter store layout: subclass ids, offsets, defaults
    // ------------------------------------------------------------
    localparam logic [7:0] SEC_SC_DATA = 8'h30;
    localparam logic [7:0] SEC_SC_MFR = 8'h39;
    localparam logic [7:0] SEC_SC_REGS = 8'h40;
    localparam logic [7:0] SEC_SC_GAUGE = 8'h50;
    localparam logic [7:0] SEC_SC_RA0 = 8'h5B;
    localparam logic [7:0] SEC_SC_RA0X = 8'h5D;
    localparam logic [7:0] SEC_SC_SECURITY = 8'h70;
    localparam int SEC_BLOCK_BYTES = 32;
    localparam int SEC_OFS_DCAP = 19;
    localparam logic [15:0] SEC_DEF_DCAP = 16'h053C;
    localparam int SEC_OFS_OPCFG = 0;
    localparam logic [7:0] SEC_DEF_OPCFG = 8'h19;
    localparam int SEC_OFS_STEP = 3;
    localparam logic [7:0] SEC_DEF_STEP = 8'h01;
    localparam int SEC_OFS_TERMV = 45;
    localparam logic [15:0] SEC_DEF_TERMV = 16'h0BB8;
    localparam int SEC_OFS_RAFLAG = 0;
    localparam logic [15:0] SEC_DEF_RA0_FLAG = 16'h0055;
    localparam logic [15:0] SEC_DEF_RA0X_FLAG = 16'h00FF;
    localparam int SEC_OFS_UNSEAL_KEY = 0;
    localparam logic [31:0] SEC_DEF_UNSEAL_KEY = 32'h36720414;
    localparam int SEC_OFS_FULL_KEY = 4;
    localparam logic [31:0] SEC_DEF_FULL_KEY = 32'hFFFFFFFF;
    localparam int SEC_OFS_RESTORE_KEY = 24;
    localparam logic [31:0] SEC_DEF_RESTORE_KEY = 32'h00000000;

    // Security levels, one-hot
    typedef enum logic [2:0] {
        SEC_SEALED = 3'h1,
        SEC_UNSEALED = 3'h2,
        SEC_FULL = 3'h4
    } sec_level_t;

endpackage : sec_pkg

// File: design/sec_if.sv
// Word-wide command link between host controller and gauge security logic.
// Assumes both ends share clk; one command outstanding at a time.
`timescale 1ns/1ps
`default_nettype none
interface sec_if (
    input wire logic clk
);
    logic cmd_valid;
    logic cmd_write;
    logic [7:0] cmd_code;
    logic [15:0] cmd_wdata;
    logic rsp_valid;
    logic rsp_err;
    logic [15:0] rsp_rdata;

    modport dev (
        input clk, cmd_valid, cmd_write, cmd_code, cmd_wdata,
        output rsp_valid, rsp_err, rsp_rdata
    );
    modport host (
        input clk, rsp_valid, rsp_err, rsp_rdata,
        output cmd_valid, cmd_write, cmd_code, cmd_wdata
    );
endinterface : sec_if
`default_nettype wire

// File: design/sec_key_pair.sv
// Two-word key sequence detector on the control word port.
// Assumes ctl_wr is a one-cycle pulse per control write.
`timescale 1ns/1ps
`default_nettype none
module sec_key_pair (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control writes
    input wire logic ctl_wr,
    input wire logic [15:0] ctl_data,
    // Expected words, already byte swapped
    input wire logic [15:0] key0,
    input wire logic [15:0] key1,
    // Result
    output logic match
);
    logic armed_q;
    logic armed_d;

    // Any control write that is neither the first nor the second word drops the sequence
    assign armed_d = ctl_wr ? (ctl_data == key0) : armed_q; // RQ5
    assign match = ctl_wr && armed_q && (ctl_data == key1); // RQ4

    // Armed after a matching first word
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            armed_q <= 1'b0;
        end
        else
        begin
            armed_q <= armed_d;
        end
    end
endmodule : sec_key_pair
`default_nettype wire

// File: design/sec_host.sv
// Host end: turns user requests into single link commands.
// Assumes the device answers every command with rsp_valid.
`timescale 1ns/1ps
`default_nettype none
module sec_host
    import sec_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Command link
    sec_if.host link,
    // User request
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_key,
    input wire logic [7:0] req_code,
    input wire logic [15:0] req_wdata,
    output logic req_ready,
    // User answer
    output logic done,
    output logic err,
    output logic [15:0] rdata
);
    logic busy_q;
    logic cmd_valid_q;
    logic cmd_write_q;
    logic [7:0] cmd_code_q;
    logic [15:0] cmd_wdata_q;
    logic done_q;
    logic err_q;
    logic [15:0] rdata_q;

    // Key words go out swapped against the stored order
    wire logic [15:0] wdata_w = req_key ? {req_wdata[7:0], req_wdata[15:8]} : req_wdata; // RQ10
    wire logic take = req_valid && !busy_q;

    // One command in flight; keys need no other writes between them
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            busy_q <= 1'b0;
            cmd_valid_q <= 1'b0;
            cmd_write_q <= 1'b0;
            cmd_code_q <= 8'h00;
            cmd_wdata_q <= 16'h0000;
            done_q <= 1'b0;
            err_q <= 1'b0;
            rdata_q <= 16'h0000;
        end
        else
        begin
            cmd_valid_q <= take; // RQ5
            done_q <= busy_q && link.rsp_valid;
            if (take)
            begin
                busy_q <= 1'b1;
                cmd_write_q <= req_write;
                cmd_code_q <= req_code; // RQ18
                cmd_wdata_q <= wdata_w;
            end
            else if (busy_q && link.rsp_valid)
            begin
                busy_q <= 1'b0;
                err_q <= link.rsp_err;
                rdata_q <= link.rsp_rdata;
            end
        end
    end

    assign link.cmd_valid = cmd_valid_q;
    assign link.cmd_write = cmd_write_q;
    assign link.cmd_code = cmd_code_q;
    assign link.cmd_wdata = cmd_wdata_q;
    assign req_ready = !busy_q;
    assign done = done_q;
    assign err = err_q;
    assign rdata = rdata_q;
endmodule : sec_host
`default_nettype wire

// File: sim/sec_properties.sv
// Concurrent checks on the link between host and device ends.
// Assumes the bench instantiates it beside the link, on the same clk and rst.
`timescale 1ns/1ps
`default_nettype none
module sec_properties
    import sec_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Link signals
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    input wire logic rsp_valid,
    input wire logic rsp_err,
    input wire logic [15:0] rsp_rdata,
    // Device user side
    input wire logic [2:0] level,
    input wire logic [15:0] ctl_status,
    input wire logic commit_pulse
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    // One domain, so clock and disable are given once
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    chk_rsp_after_cmd: assert property (cmd_valid |=> rsp_valid)
        else $error("no answer one cycle after a command");
    chk_rsp_no_stray: assert property (rsp_valid |-> $past(cmd_valid))
        else $error("answer without a command");
    chk_err_rdata_zero: assert property (rsp_valid && rsp_err |-> rsp_rdata == 16'h0000)
        else $error("refused answer carries data");
    chk_level_onehot: assert property ($onehot(level))
        else $error("level is not one of three");
    chk_sealed_flag: assert property (ctl_status[SEC_SS_BIT] == (level == SEC_SEALED))
        else $error("sealed flag disagrees with level");
    chk_full_flag: assert property (ctl_status[SEC_FAS_BIT] == (level != SEC_FULL))
        else $error("full access flag disagrees with level");
    chk_class_sealed: assert property (level == SEC_SEALED && cmd_valid
        && cmd_code == SEC_CMD_CLASS |=> rsp_valid && rsp_err)
        else $error("class select accepted while sealed");
    chk_block_sealed: assert property (level == SEC_SEALED && cmd_valid && cmd_write
        && cmd_code == SEC_CMD_BLOCK && cmd_wdata != 16'h0001 |=> rsp_err)
        else $error("general block select accepted while sealed");
    // A level moves only on the edge that takes a control word write
    chk_level_ctl_only: assert property ($changed(level)
        |-> $past(cmd_valid && cmd_write && cmd_code == SEC_CMD_CTL))
        else $error("level changed without a control write");
    chk_no_skip_level: assert property (level == SEC_SEALED |=> level != SEC_FULL)
        else $error("sealed jumped straight to full access");
    chk_seal_cmd: assert property (cmd_valid && cmd_write && cmd_code == SEC_CMD_CTL
        && cmd_wdata == SEC_SUB_SEAL |=> level == SEC_SEALED)
        else $error("seal subcommand did not seal");
    chk_commit_cause: assert property (commit_pulse |-> rsp_valid && !rsp_err)
        else $error("commit without an accepted answer");
endmodule : sec_properties
`default_nettype wire

// File: sim/tb.sv
// Bench joining host and device ends over one link, driven from the host user side.
// Assumes the device answers each command one cycle later, as the link promises.
`timescale 1ns/1ps
`default_nettype none
module tb
    import sec_pkg::*;
    ;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic req_key = 1'b0;
    logic [7:0] req_code = 8'h00;
    logic [15:0] req_wdata = 16'h0000;
    logic req_ready, done, err, commit_pulse;
    logic [2:0] level;
    logic [15:0] rdata, ctl_status;
    logic [15:0] last_wd = 16'h0000;
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0, commits = 0;

    // ------------------------------------------------------------
    // Ends, link and checker
    // ------------------------------------------------------------
    always #20 clk = ~clk;
    sec_if sec_if_inst (.clk(clk));
    sec_device sec_device_inst (.clk(clk), .rst(rst), .link(sec_if_inst), .level(level),
        .ctl_status(ctl_status), .commit_pulse(commit_pulse));
    sec_host sec_host_inst (.clk(clk), .rst(rst), .link(sec_if_inst), .req_valid(req_valid),
        .req_write(req_write), .req_key(req_key), .req_code(req_code), .req_wdata(req_wdata),
        .req_ready(req_ready), .done(done), .err(err), .rdata(rdata));
    sec_properties sec_properties_inst (.clk(clk), .rst(rst),
        .cmd_valid(sec_if_inst.cmd_valid), .cmd_write(sec_if_inst.cmd_write),
        .cmd_code(sec_if_inst.cmd_code), .cmd_wdata(sec_if_inst.cmd_wdata),
        .rsp_valid(sec_if_inst.rsp_valid), .rsp_err(sec_if_inst.rsp_err),
        .rsp_rdata(sec_if_inst.rsp_rdata), .level(level), .ctl_status(ctl_status),
        .commit_pulse(commit_pulse));

    // Wire monitor and hang guard; a run needs well under 1500 cycles
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (sec_if_inst.cmd_valid === 1'b1)
            last_wd <= sec_if_inst.cmd_wdata;
        if (commit_pulse === 1'b1)
            commits <= commits + 1;
        if (cycles == 4000)
        begin
            errors++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : print_verdict

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    // One request, held until taken, then wait for done; entered just after an edge
    task automatic req(input logic w, input logic k, input logic [7:0] c,
        input logic [15:0] d);
        int n;
        req_valid <= 1'b1;
        req_write <= w;
        req_key <= k;
        req_code <= c;
        req_wdata <= d;
        n = 0;
        @(posedge clk);
        while (req_ready !== 1'b1 && n < 10)
        begin
            @(posedge clk);
            n++;
        end
        req_valid <= 1'b0;
        while (done !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 20)
            check(16'hDEAD, 16'h0000);
    endtask : req

    // Request whose refusal flag is compared
    task automatic req_e(input logic w, input logic [7:0] c, input logic [15:0] d,
        input logic e);
        req(w, 1'b0, c, d);
        check({15'h0000, err}, {15'h0000, e});
    endtask : req_e

    // Control word pair given as stored words; the host swaps the bytes
    task automatic keys(input logic [15:0] a, input logic [15:0] b);
        req(1'b1, 1'b1, SEC_CMD_CTL, a);
        req(1'b1, 1'b1, SEC_CMD_CTL, b);
    endtask : keys

    // General store selection of one subclass block
    task automatic sel(input logic [7:0] cls, input logic [7:0] blk);
        req(1'b1, 1'b0, SEC_CMD_BCTL, 16'h0000);
        req(1'b1, 1'b0, SEC_CMD_CLASS, {8'h00, cls});
        req(1'b1, 1'b0, SEC_CMD_BLOCK, {8'h00, blk});
    endtask : sel

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_sealed();
        check({13'h0000, level}, 16'h0001);
        check(ctl_status, 16'h6000);
        req_e(1'b1, SEC_CMD_CLASS, 16'h0039, 1'b1);
        req_e(1'b1, SEC_CMD_BLOCK, 16'h0000, 1'b1);
        req_e(1'b1, SEC_CMD_BLOCK, 16'h0001, 1'b0);
        req_e(1'b0, SEC_CMD_DATA_LO + 8'h05, 16'h0000, 1'b0);
        check(rdata, 16'h0000);
        req_e(1'b1, SEC_CMD_DATA_LO, 16'h00AB, 1'b1);
    endtask : t_sealed

    // Wrong order and a stray word in between leave the level alone
    task automatic t_pairs();
        keys(16'h0414, 16'h3672);
        check({13'h0000, level}, 16'h0001);
        req(1'b1, 1'b1, SEC_CMD_CTL, 16'h3672);
        req(1'b1, 1'b1, SEC_CMD_CTL, 16'h1111);
        req(1'b1, 1'b1, SEC_CMD_CTL, 16'h0414);
        check({13'h0000, level}, 16'h0001);
        check(ctl_status, 16'h6000);
        check(last_wd, 16'h1404);
        keys(16'h3672, 16'h0414);
        check({13'h0000, level}, 16'h0002);
        check(ctl_status, 16'h4000);
    endtask : t_pairs

    // Entries: subclass, offset, expected byte; offset bit 5 picks the block
    task automatic t_defaults();
        logic [23:0] tab [0:13];
        tab = '{24'h301305, 24'h30143C, 24'h400019, 24'h400301, 24'h502D0B, 24'h502EB8,
            24'h5B0000, 24'h5B0155, 24'h5D01FF, 24'h391F00, 24'h700036, 24'h700314,
            24'h7004FF, 24'h701800};
        for (int i = 0; i < 14; i++)
        begin
            sel(tab[i][23:16], {7'h00, tab[i][13]});
            req(1'b0, 1'b0, SEC_CMD_DATA_LO + {3'h0, tab[i][12:8]}, 16'h0000);
            check(rdata, {8'h00, tab[i][7:0]});
        end
    endtask : t_defaults

    // Bad checksum is refused; good one commits; keys stay locked below full access
    task automatic t_commit();
        int c0;
        sel(SEC_SC_MFR, 8'h00);
        req(1'b1, 1'b0, SEC_CMD_DATA_LO, 16'h00AB);
        c0 = commits;
        req_e(1'b1, SEC_CMD_CKSUM, 16'h0000, 1'b1);
        req_e(1'b1, SEC_CMD_CKSUM, 16'h0054, 1'b0);
        @(posedge clk);
        check(16'(commits - c0), 16'h0001);
        sel(SEC_SC_DATA, 8'h00);
        sel(SEC_SC_MFR, 8'h00);
        req(1'b0, 1'b0, SEC_CMD_DATA_LO, 16'h0000);
        check(rdata, 16'h00AB);
        sel(SEC_SC_SECURITY, 8'h00);
        req(1'b1, 1'b0, SEC_CMD_DATA_LO, 16'h0000);
        req_e(1'b1, SEC_CMD_CKSUM, 16'h0079, 1'b1);
    endtask : t_commit

    // Full access rewrites the unseal key, which then governs unsealing
    task automatic t_full();
        int c0;
        keys(16'hFFFF, 16'hFFFF);
        check({13'h0000, level}, 16'h0004);
        check(ctl_status, 16'h0000);
        sel(SEC_SC_SECURITY, 8'h00);
        req(1'b1, 1'b0, SEC_CMD_DATA_LO, 16'h0000);
        c0 = commits;
        req_e(1'b1, SEC_CMD_CKSUM, 16'h0079, 1'b0);
        @(posedge clk);
        check(16'(commits - c0), 16'h0001);
        req(1'b1, 1'b0, SEC_CMD_CTL, SEC_SUB_SEAL);
        check({13'h0000, level}, 16'h0001);
        keys(16'h3672, 16'h0414);
        check({13'h0000, level}, 16'h0001);
        keys(16'h0072, 16'h0414);
        check({13'h0000, level}, 16'h0002);
        check(last_wd, 16'h1404);
    endtask : t_full

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_sealed();
        t_pairs();
        t_defaults();
        t_commit();
        t_full();
        print_verdict();
    end
endmodule : tb
`default_nettype wire
